/* File: rtl/rtc_i2c_host.sv */
module fifo_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,        // system clock
    input  wire logic             rst_b,      // async reset
    input  wire logic [WIDTH-1:0] in_data,    // word in
    input  wire logic             in_valid,   // word offered
    output logic                  in_ready,   // room left
    output logic [WIDTH-1:0]      out_data,   // oldest word
    output logic                  out_valid,  // not empty
    input  wire logic             out_ready   // word taken
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire              push       = in_valid & in_ready;
    wire              pop        = out_valid & out_ready;
    wire [AW:0]       next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= wr_ptr + AW'(push);
            rd_ptr    <= rd_ptr + AW'(pop);
            count     <= next_count;
            in_ready  <= next_count != (AW+1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end

endmodule // fifo_buf

module rtc_i2c_host
    import rtc_i2c_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,          // system clock
    input  wire logic             rst_b,        // async reset
    i2c_link_if.host              link,         // two-wire bus
    input  wire logic             cmd_valid,    // transfer request
    output logic                  cmd_ready,    // idle, may accept
    input  wire logic             cmd_read,     // 1 read, 0 write
    input  wire logic [PTR_W-1:0] cmd_ptr,      // first register
    input  wire logic [7:0]       cmd_len,      // data byte count
    input  wire logic [7:0]       wdata,        // write byte
    input  wire logic             wdata_valid,  // write byte offered
    output logic                  wdata_ready,  // buffer has room
    output logic [7:0]            rdata,        // read byte
    output logic                  rdata_valid,  // read byte pulse
    output logic                  busy,         // transfer running
    output logic                  nack_err      // device refused
);

    if (STEP_CYC < 1 || STEP_CYC > 255) begin : g_bad_step
        $error("step count out of range");
    end

    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_BYTE  = 3'b011,
        H_LOAD  = 3'b010,
        H_STOP  = 3'b110
    } host_state_e;

    typedef enum logic [2:0] {G_AW, G_PTR, G_DW, G_AR, G_DR} stage_e;

    localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

    host_state_e      state;
    stage_e           stage;
    logic [7:0]       div;
    logic [1:0]       stp;
    logic [3:0]       bit_idx;
    logic [8:0]       tx;
    logic [7:0]       rx;
    logic [7:0]       len;
    logic [PTR_W-1:0] ptr;
    logic             read_op;
    logic             scl_low;
    logic             sda_low;
    logic [1:0]       sda_s;
    logic [7:0]       f_data;
    logic             f_valid;

    wire tick     = div == STEP_LAST;
    wire sda_in   = sda_s[1];
    wire ack      = ~sda_in;
    wire byte_end = tick & (stp == 2'h2) & (bit_idx == 4'h8);
    wire f_pop    = (state == H_LOAD) & f_valid;

    assign link.scl_o    = 1'b0;
    assign link.scl_oe   = scl_low;
    assign link.sda_m_o  = 1'b0;
    assign link.sda_m_oe = sda_low;

    fifo_buf #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_data   (wdata),
        .in_valid  (wdata_valid),
        .in_ready  (wdata_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_s <= 2'h3;
            div   <= 8'h00;
        end else begin
            sda_s <= {sda_s[0], link.sda};
            div   <= (tick || state == H_IDLE) ? 8'h00 : div + 8'h01;
        end
    end

    // ****************************************
    // bus sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= H_IDLE;
            stage       <= G_AW;
            stp         <= 2'h0;
            bit_idx     <= 4'h0;
            tx          <= 9'h1ff;
            rx          <= 8'h00;
            len         <= 8'h00;
            ptr         <= '0;
            read_op     <= 1'b0;
            scl_low     <= 1'b0;
            sda_low     <= 1'b0;
            cmd_ready   <= 1'b1;
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
            busy        <= 1'b0;
            nack_err    <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        state     <= H_START;
                        stage     <= G_AW;
                        stp       <= 2'h0;
                        cmd_ready <= 1'b0;
                        busy      <= 1'b1;
                        nack_err  <= 1'b0;
                        read_op   <= cmd_read;
                        ptr       <= cmd_ptr;
                        len       <= cmd_len;
                    end
                end
                H_START: if (tick) begin
                    stp <= stp + 2'h1;
                    case (stp)
                        2'h0: sda_low <= 1'b0;
                        2'h1: scl_low <= 1'b0;
                        2'h2: sda_low <= 1'b1;
                        default: begin
                            scl_low <= 1'b1;
                            state   <= H_BYTE;
                            bit_idx <= 4'h0;
                            tx      <= {SLAVE_ADDR, stage == G_AR, 1'b1};
                        end
                    endcase
                end
                H_BYTE: if (tick) begin
                    stp <= (stp == 2'h2) ? 2'h0 : stp + 2'h1;
                    case (stp)
                        2'h0: sda_low <= ~tx[8];
                        2'h1: scl_low <= 1'b0;
                        default: begin
                            scl_low <= 1'b1;
                            tx      <= {tx[7:0], 1'b1};
                            bit_idx <= bit_idx + 4'h1;
                            if (bit_idx != 4'h8) begin
                                rx <= {rx[6:0], sda_in};
                            end
                        end
                    endcase
                    if (byte_end) begin
                        bit_idx <= 4'h0;
                        if (!ack && stage != G_DR) begin
                            nack_err <= 1'b1;
                            state    <= H_STOP;
                        end else begin
                            case (stage)
                                G_AW: begin
                                    stage <= G_PTR;
                                    tx    <= {4'h0, ptr, 1'b1};
                                end
                                G_PTR: begin
                                    if (len == 8'h00) begin
                                        state <= H_STOP;
                                    end else if (read_op) begin
                                        stage <= G_AR;
                                        state <= H_START;
                                    end else begin
                                        stage <= G_DW;
                                        state <= H_LOAD;
                                    end
                                end
                                G_DW: begin
                                    len   <= len - 8'h01;
                                    state <= (len == 8'h01) ? H_STOP : H_LOAD;
                                end
                                G_AR: begin
                                    stage <= G_DR;
                                    tx    <= {8'hff, len == 8'h01};
                                end
                                default: begin
                                    rdata       <= rx;
                                    rdata_valid <= 1'b1;
                                    len         <= len - 8'h01;
                                    tx          <= {8'hff, len == 8'h02};
                                    if (len == 8'h01) begin
                                        state <= H_STOP;
                                    end
                                end
                            endcase
                        end
                    end
                end
                H_LOAD: begin
                    if (f_valid) begin
                        state <= H_BYTE;
                        stp   <= 2'h0;
                        tx    <= {f_data, 1'b1};
                    end
                end
                H_STOP: if (tick) begin
                    stp <= stp + 2'h1;
                    case (stp)
                        2'h0: sda_low <= 1'b1;
                        2'h1: scl_low <= 1'b0;
                        default: begin
                            sda_low   <= 1'b0;
                            state     <= H_IDLE;
                            busy      <= 1'b0;
                            cmd_ready <= 1'b1;
                        end
                    endcase
                end
                default: begin
                    state   <= H_IDLE;
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

endmodule // rtc_i2c_host

/* File: rtl/rtc_i2c_pkg.sv */
package rtc_i2c_pkg;

    // ****************************************
    // addressing
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h51;
    localparam int         PTR_W      = 4;
    localparam logic       RW_READ    = 1'b1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ  = 25;
    localparam int STEP_NS  = 320;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;

    // ****************************************
    // buffering
    // ****************************************
    localparam int FIFO_DEPTH = 32;

endpackage

/* File: rtl/i2c_link_if.sv */
interface i2c_link_if;

    logic scl_o;     // host clock level when driven
    logic scl_oe;    // host drives clock
    logic sda_m_o;   // host data level when driven
    logic sda_m_oe;  // host drives data
    logic sda_s_o;   // device data level when driven
    logic sda_s_oe;  // device drives data

    // open-drain wires with pull-up
    wire scl = scl_oe ? scl_o : 1'b1;
    wire sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

    modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport host   (input scl, input sda, output scl_o, output scl_oe,
                    output sda_m_o, output sda_m_oe);

endinterface

/* File: rtl/rtc_i2c_device.sv */
module rtc_i2c_device
    import rtc_i2c_pkg::*;
(
    input  wire logic             clk,          // system clock
    input  wire logic             rst_b,        // async reset
    i2c_link_if.device            link,         // two-wire bus
    output logic [PTR_W-1:0]      reg_addr,     // register of strobe
    output logic [7:0]            wr_data,      // byte written
    output logic                  wr_stb,       // write pulse
    output logic                  rd_stb,       // read request pulse
    input  wire logic [7:0]       rd_data,      // byte to send
    output logic                  access_busy,  // counters frozen
    input  wire logic             tick_req,     // one-second tick
    output logic                  tick_apply    // tick to counters
);

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RECV = 3'b001,
        D_RACK = 3'b011,
        D_SEND = 3'b010,
        D_SACK = 3'b110,
        D_SKIP = 3'b111
    } dev_state_e;

    dev_state_e       state;
    logic [2:0]       scl_s;
    logic [2:0]       sda_s;
    logic [3:0]       bit_cnt;
    logic [7:0]       shreg;
    logic [7:0]       tx;
    logic [PTR_W-1:0] ptr;
    logic             is_addr;
    logic             is_ptr;
    logic             rd_mode;
    logic             acked;
    logic             pending;
    logic             oe;

    // ****************************************
    // line sampling
    // ****************************************
    wire scl_hi    = scl_s[1] & scl_s[2];
    wire start_det = scl_hi & sda_s[2] & ~sda_s[1];
    wire stop_det  = scl_hi & ~sda_s[2] & sda_s[1];
    wire scl_rise  = scl_s[1] & ~scl_s[2];
    wire scl_fall  = ~scl_s[1] & scl_s[2];
    wire sda_in    = sda_s[1];
    wire byte_end  = scl_fall & (bit_cnt == 4'h8);
    wire addr_hit  = shreg[7:1] == SLAVE_ADDR;

    assign link.sda_s_o  = 1'b0;
    assign link.sda_s_oe = oe;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], link.scl};
            sda_s <= {sda_s[1:0], link.sda};
        end
    end

    // ****************************************
    // byte engine
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= D_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            tx          <= 8'h00;
            ptr         <= '0;
            reg_addr    <= '0;
            wr_data     <= 8'h00;
            wr_stb      <= 1'b0;
            rd_stb      <= 1'b0;
            is_addr     <= 1'b0;
            is_ptr      <= 1'b0;
            rd_mode     <= 1'b0;
            acked       <= 1'b0;
            access_busy <= 1'b0;
            oe          <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (start_det) begin
                state       <= D_RECV;
                bit_cnt     <= 4'h0;
                is_addr     <= 1'b1;
                oe          <= 1'b0;
                access_busy <= 1'b0;
            end else if (stop_det) begin
                state       <= D_IDLE;
                oe          <= 1'b0;
                access_busy <= 1'b0;
            end else begin
                case (state)
                    D_RECV: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_end && is_addr) begin
                            is_addr <= 1'b0;
                            if (addr_hit) begin
                                state       <= D_RACK;
                                oe          <= 1'b1;
                                rd_mode     <= shreg[0] == RW_READ;
                                is_ptr      <= shreg[0] != RW_READ;
                                access_busy <= 1'b1;
                            end else begin
                                state <= D_SKIP;
                            end
                        end else if (byte_end && is_ptr) begin
                            state  <= D_RACK;
                            oe     <= 1'b1;
                            is_ptr <= 1'b0;
                            ptr    <= shreg[PTR_W-1:0];
                        end else if (byte_end) begin
                            state    <= D_RACK;
                            oe       <= 1'b1;
                            wr_stb   <= 1'b1;
                            wr_data  <= shreg;
                            reg_addr <= ptr;
                            ptr      <= ptr + PTR_W'(1);
                        end
                    end
                    D_RACK: begin
                        if (scl_rise && rd_mode) begin
                            rd_stb   <= 1'b1;
                            reg_addr <= ptr;
                        end
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rd_mode) begin
                                state <= D_SEND;
                                tx    <= rd_data;
                                oe    <= ~rd_data[7];
                            end else begin
                                state <= D_RECV;
                                oe    <= 1'b0;
                            end
                        end
                    end
                    D_SEND: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_end) begin
                            state <= D_SACK;
                            oe    <= 1'b0;
                            ptr   <= ptr + PTR_W'(1);
                        end else if (scl_fall) begin
                            tx <= {tx[6:0], 1'b0};
                            oe <= ~tx[6];
                        end
                    end
                    D_SACK: begin
                        if (scl_rise) begin
                            acked    <= ~sda_in;
                            rd_stb   <= ~sda_in;
                            reg_addr <= ptr;
                        end
                        if (scl_fall && acked) begin
                            state   <= D_SEND;
                            bit_cnt <= 4'h0;
                            tx      <= rd_data;
                            oe      <= ~rd_data[7];
                        end else if (scl_fall) begin
                            state <= D_SKIP;
                        end
                    end
                    D_SKIP: begin
                        oe <= 1'b0;
                    end
                    default: begin
                        state <= D_IDLE;
                        oe    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // counter freeze
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending    <= 1'b0;
            tick_apply <= 1'b0;
        end else begin
            tick_apply <= ~access_busy & (pending | tick_req);
            pending    <= access_busy & (pending | tick_req);
        end
    end

endmodule // rtc_i2c_device

/* File: dv/rtc_i2c_slave_port_checker.sv */
module rtc_i2c_slave_port_checker
    import rtc_i2c_pkg::*;
(
    input wire logic clk,      // system clock
    input wire logic rst_b,    // async reset
    input wire logic scl,      // bus clock wire
    input wire logic sda,      // bus data wire
    input wire logic scl_oe,   // host pulls clock
    input wire logic sda_s_oe  // device pulls data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sda_q, scl_q, idle, first, rd;
    logic [3:0] cnt;
    logic [7:0] sh;
    wire        rise  = scl & !scl_q;
    wire        start = scl & scl_q & sda_q & !sda;
    wire        stop  = scl & scl_q & !sda_q & sda;
    wire        ack   = rise & (cnt == 4'h8);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ********************
    // bit and byte tracker
    // ********************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {sda_q, scl_q, idle, first, rd} <= 5'h1c;
            cnt <= 4'h0;
            sh  <= 8'h00;
        end else begin
            sda_q <= sda;
            scl_q <= scl;
            if (start | stop) begin
                idle  <= stop;
                first <= start;
                cnt   <= 4'h0;
            end else if (rise) begin
                sh  <= {sh[6:0], sda};
                cnt <= ack ? 4'h0 : cnt + 4'h1;
                if (ack) first <= 1'b0;
                if (ack & first) rd <= sh[0];
            end
        end
    end
    // ********************
    // properties
    // ********************
    a_steady_clock_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
        else $error("device data moved with clock high");
    a_idle_released: assert property (idle |-> !sda_s_oe && !scl_oe)
        else $error("line pulled on idle bus");
    // the clock rise before a control condition has already counted one
    a_ctrl_on_frame: assert property (start || stop |-> cnt < 4'h2)
        else $error("control condition inside a byte");
    a_addr_ack_match: assert property (ack && first |->
        sda_s_oe == (sh[7:1] == SLAVE_ADDR))
        else $error("address acknowledge wrong");
    a_addr_sent_first: assert property (ack && first |-> sh[7:1] == SLAVE_ADDR)
        else $error("first byte not the address");
    a_write_byte_ack: assert property (ack && !first && !rd |-> sda_s_oe)
        else $error("received byte not acknowledged");
    a_ack_held_high: assert property (ack && sda_s_oe |-> sda_s_oe [*8])
        else $error("acknowledge dropped early");
    a_nack_release: assert property (ack && !first && rd && sda |->
        !sda_s_oe throughout (##[1:64] stop))
        else $error("no release or stop after nack");
    c_write_ack: cover property (ack && !first && !rd && sda_s_oe);
    c_read_nack: cover property (ack && !first && rd && sda);
    c_restart: cover property (start && !idle);
endmodule // rtc_i2c_slave_port_checker

/* File: dv/rtc_i2c_slave_port_bench.sv */
module rtc_i2c_slave_port_bench
    import rtc_i2c_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, cmd_valid = 0, cmd_read = 0, wdata_valid = 0, tick_req = 0;
    logic [3:0] cmd_ptr = 4'h0;
    logic [7:0] cmd_len = 8'h0, wdata = 8'h0, rd_data = 8'h0;
    logic [7:0] mem [16];
    logic [7:0] rq [$];
    wire  [3:0] reg_addr;
    wire  [7:0] wr_data, rdata;
    wire        wr_stb, rd_stb, access_busy, tick_apply, cmd_ready, wdata_ready;
    wire        rdata_valid, busy, nack_err;
    int         err_count = 0, cmp_count = 0, napply = 0;
    i2c_link_if link ();
    rtc_i2c_device u_rtc_i2c_device (.clk, .rst_b, .link, .reg_addr, .wr_data, .wr_stb,
        .rd_stb, .rd_data, .access_busy, .tick_req, .tick_apply);
    rtc_i2c_host u_rtc_i2c_host (.clk, .rst_b, .link, .cmd_valid, .cmd_ready, .cmd_read,
        .cmd_ptr, .cmd_len, .wdata, .wdata_valid, .wdata_ready, .rdata, .rdata_valid,
        .busy, .nack_err);
    rtc_i2c_slave_port_checker u_rtc_i2c_slave_port_checker (.clk, .rst_b, .scl(link.scl),
        .sda(link.sda), .scl_oe(link.scl_oe), .sda_s_oe(link.sda_s_oe));
    initial forever #20 clk = ~clk;
    // ********************
    // register file stand-in
    // ********************
    always @(posedge clk) begin
        if (wr_stb) mem[reg_addr] <= wr_data;
        if (rd_stb) rd_data <= mem[reg_addr];
        if (rdata_valid) rq.push_back(rdata);
        if (tick_apply) napply <= napply + 1;
        if (tick_apply) chk({7'h0, access_busy}, 8'h0);
    end
    // ********************
    // tasks
    // ********************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic push(input logic [7:0] d);
        {wdata_valid, wdata} = {1'b1, d};
        @(posedge clk) #1;
    endtask
    task automatic run(input logic rd, input logic [3:0] ptr, input logic [7:0] len);
        int n;
        n = 0;
        {cmd_valid, cmd_read, cmd_ptr, cmd_len} = {1'b1, rd, ptr, len};
        @(posedge clk) #1 cmd_valid = 1'b0;
        while (busy !== 1'b0 || cmd_ready !== 1'b1) begin
            @(posedge clk) #1;
            if (++n > 20000) begin
                chk(8'h1, 8'h0);
                final_report();
            end
        end
        chk({7'h0, nack_err}, 8'h0);
    endtask
    task automatic write_wrap();
        for (int i = 0; i < 3; i++) push(8'ha0 + 8'(i));
        wdata_valid = 1'b0;
        run(1'b0, 4'he, 8'h03);
        chk(mem[14], 8'ha0);
        chk(mem[15], 8'ha1);
        chk(mem[0], 8'ha2);
    endtask
    task automatic read_frozen();
        rq.delete();
        fork
            run(1'b1, 4'he, 8'h03);
            begin
                repeat (280) @(posedge clk);
                repeat (2) begin
                    #1 tick_req = 1'b1;
                    @(posedge clk) #1 tick_req = 1'b0;
                    repeat (20) @(posedge clk);
                end
            end
        join
        chk(8'(napply), 8'h01);
        chk(8'(rq.size()), 8'h03);
        for (int i = 0; i < 3; i++) chk(rq[i], 8'ha0 + 8'(i));
    endtask
    task automatic fifo_fill();
        for (int i = 0; i < 33; i++) push(8'(i));
        wdata_valid = 1'b0;
        chk({7'h0, wdata_ready}, 8'h00);
        run(1'b0, 4'h0, 8'h20);
        for (int i = 0; i < 16; i++) chk(mem[i], 8'(i + 16));
        chk({7'h0, wdata_ready}, 8'h01);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        write_wrap();
        read_frozen();
        fifo_fill();
        final_report();
    end
endmodule // rtc_i2c_slave_port_bench
